// >>> exec_pkg.sv
// Package: opcode fields, operation codes and timing for the execution unit
// Assumes: one 100 MHz clock; opcodes arrive as full 24-bit words
`default_nettype none
package exec_pkg;
   localparam int CLK_PERIOD_NS        = 10;
   localparam logic [4:0] REV_SUB_PATTERN = 5'h02;
   localparam int OPC_TOP              = 23;
   localparam int BASE_REG_LSB         = 15;
   localparam int SIZE_BIT_POS         = 14;
   localparam int DEST_MODE_LSB        = 11;
   localparam int DEST_REG_LSB         = 7;
   localparam int SRC_MODE_LSB         = 4;
   localparam int SRC_REG_LSB          = 0;
   localparam logic [2:0] MODE_DIRECT  = 3'h0;
   localparam logic [2:0] MODE_IND     = 3'h1;
   localparam logic [2:0] MODE_POSTDEC = 3'h2;
   localparam logic [2:0] MODE_POSTINC = 3'h3;
   localparam logic [2:0] MODE_PREDEC  = 3'h4;
   localparam logic [2:0] MODE_PREINC  = 3'h5;
   localparam logic [15:0] WORD_RESET  = 16'h0000;
   localparam int TABLE_HIGH_CYCLES    = 2;
   typedef enum logic [1:0] {
      OP_REV_SUB,
      OP_SWAP,
      OP_TBL_LOW,
      OP_TBL_HIGH
   } exec_op_t;
endpackage : exec_pkg
`default_nettype wire

// >>> operand_bus_if.sv
// Interface: operand fetch and result path between sequencer and ALU
// Assumes: both ends share the core clock
`default_nettype none
interface operand_bus_if;
   logic [1:0]  op;
   logic        byte_mode;
   logic [15:0] src_val;
   logic [15:0] base_val;
   logic [15:0] dest_old;
   logic        src_odd;
   logic [23:0] pm_word;
   logic [15:0] result;
   logic [4:0]  flags;
   modport seq (output op, byte_mode, src_val, base_val, dest_old,
                src_odd, pm_word, input result, flags);
   modport alu (input op, byte_mode, src_val, base_val, dest_old,
                src_odd, pm_word, output result, flags);
endinterface : operand_bus_if
`default_nettype wire

// >>> exec_alu.sv
// Combinational result logic for the four operations; flags come from subtract only
// Assumes: operands are stable for the cycle in which result is taken
`default_nettype none
module exec_alu
   import exec_pkg::*;
(
   operand_bus_if.alu bus
);
   logic [16:0] diff_w;
   logic [8:0]  diff_b;
   logic [4:0]  dig;
   logic [15:0] res;
   logic [4:0]  fl;

   always_comb begin
      diff_w = {1'b0, bus.src_val} - {1'b0, bus.base_val};
      diff_b = {1'b0, bus.src_val[7:0]} - {1'b0, bus.base_val[7:0]};
      dig    = {1'b0, bus.src_val[3:0]} - {1'b0, bus.base_val[3:0]};
      res    = WORD_RESET;
      fl     = 5'h00;
      case (exec_op_t'(bus.op))
         OP_REV_SUB: begin
            if (bus.byte_mode) begin
               res = {bus.dest_old[15:8], diff_b[7:0]};
               fl[4] = ~dig[4];
               fl[3] = diff_b[7];
               fl[2] = (bus.src_val[7] ^ bus.base_val[7])
                     & (bus.src_val[7] ^ diff_b[7]);
               fl[1] = (diff_b[7:0] == 8'h00);
               fl[0] = ~diff_b[8];
            end else begin
               res = diff_w[15:0];
               fl[4] = ~dig[4];
               fl[3] = diff_w[15];
               fl[2] = (bus.src_val[15] ^ bus.base_val[15])
                     & (bus.src_val[15] ^ diff_w[15]);
               fl[1] = (diff_w[15:0] == 16'h0000);
               fl[0] = ~diff_w[16];
            end
         end
         OP_SWAP: begin
            if (bus.byte_mode)
               res = {bus.src_val[15:8], bus.src_val[3:0],
                      bus.src_val[7:4]};
            else
               res = {bus.src_val[7:0], bus.src_val[15:8]};
         end
         OP_TBL_LOW: begin
            if (!bus.byte_mode)
               res = bus.pm_word[15:0];
            else if (bus.src_odd)
               res = {bus.dest_old[15:8], bus.pm_word[15:8]};
            else
               res = {bus.dest_old[15:8], bus.pm_word[7:0]};
         end
         default: begin
            if (!bus.byte_mode)
               res = {8'h00, bus.pm_word[23:16]};
            else if (bus.src_odd)
               res = {bus.dest_old[15:8], 8'h00};
            else
               res = {bus.dest_old[15:8], bus.pm_word[23:16]};
         end
      endcase
      bus.result = res;
      bus.flags  = fl;
   end
endmodule // exec_alu
`default_nettype wire

// >>> exec_unit.sv
// Execution sequencer: decode, operand fetch, table read, write-back
// Assumes: register file and data memory answer reads combinationally;
// program memory answers a read in the same cycle its address and pmem_re stand
`default_nettype none
module exec_unit
   import exec_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Decode side
   input  wire logic        issue,
   input  wire logic [1:0]  op_sel,
   input  wire logic [23:0] opcode,
   input  wire logic [7:0]  table_page_pointer,
   output logic             busy,
   output logic             done,
   output logic [4:0]       status_flags,
   output logic             flags_valid,
   // Register file
   output logic             wreg_we,
   output logic [3:0]       wreg_waddr,
   output logic [15:0]      wreg_wdata,
   // Data memory
   output logic             dmem_we,
   output logic [15:0]      dmem_addr,
   output logic [15:0]      dmem_wdata,
   input  wire logic [15:0] dmem_rdata,
   // Program memory
   output logic             pmem_re,
   output logic [23:0]      program_memory_word_addr,
   input  wire logic [23:0] program_memory_word
);
   typedef enum logic [1:0] {S_IDLE, S_EXEC, S_TBL_WAIT} state_t;
   state_t state_reg;
   logic [15:0] regs [16];
   logic [23:0] op_reg;
   exec_op_t    kind_reg;
   operand_bus_if bus ();

   exec_alu u_alu (.bus(bus));

   // Effective address and register update for one addressing mode
   function automatic logic [15:0] eff_addr(input logic [2:0] m,
                                           input logic [15:0] r,
                                           input logic b);
      logic [15:0] step;
      step = b ? 16'h0001 : 16'h0002;
      if (m == MODE_PREDEC)      eff_addr = r - step;
      else if (m == MODE_PREINC) eff_addr = r + step;
      else                       eff_addr = r;
   endfunction
   function automatic logic [15:0] upd_reg(input logic [2:0] m,
                                          input logic [15:0] r,
                                          input logic b);
      logic [15:0] step;
      step = b ? 16'h0001 : 16'h0002;
      if (m == MODE_POSTINC || m == MODE_PREINC)      upd_reg = r + step;
      else if (m == MODE_POSTDEC || m == MODE_PREDEC) upd_reg = r - step;
      else                                            upd_reg = r;
   endfunction

   // Opcode fields
   logic [3:0]  base_operand_reg, dest_operand_reg, source_operand_reg;
   logic [2:0]  dmode, smode;
   logic        bmode;
   logic [15:0] src_ea, dst_ea;
   assign base_operand_reg   = op_reg[BASE_REG_LSB +: 4];
   assign dest_operand_reg   = op_reg[DEST_REG_LSB +: 4];
   assign source_operand_reg = op_reg[SRC_REG_LSB +: 4];
   assign dmode = op_reg[DEST_MODE_LSB +: 3];
   assign smode = op_reg[SRC_MODE_LSB +: 3];
   assign bmode = op_reg[SIZE_BIT_POS];
   assign src_ea = eff_addr(smode, regs[source_operand_reg], bmode);
   assign dst_ea = eff_addr(dmode, regs[dest_operand_reg], bmode);

   // Swap writes its own register; the others write the destination
   logic [3:0]  wb_reg;
   logic [15:0] wb_old;
   assign wb_reg = (kind_reg == OP_SWAP) ? source_operand_reg
                                         : dest_operand_reg;
   assign wb_old = regs[wb_reg];

   // Decoded opcode must carry the subtract pattern for that operation
   logic legal;
   assign legal = (op_sel != 2'(OP_REV_SUB))
               || (opcode[OPC_TOP -: 5] == REV_SUB_PATTERN);

   chk_illegal_drop: assert property (@(posedge clk)
      disable iff (!rstn)
      (state_reg == S_IDLE && issue && !legal) |=> !busy)
      else $error("Illegal subtract opcode was taken");

   // ------------------------------------------------------------------
   // Operand routing into the ALU
   // ------------------------------------------------------------------
   always_comb begin
      bus.op        = kind_reg;
      bus.byte_mode = bmode;
      bus.base_val  = regs[base_operand_reg];
      bus.src_val   = (smode == MODE_DIRECT || kind_reg == OP_SWAP)
                    ? regs[source_operand_reg] : dmem_rdata;
      bus.dest_old  = regs[dest_operand_reg];
      bus.src_odd   = src_ea[0];
      bus.pm_word   = program_memory_word;
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   logic finish;
   assign finish = (state_reg == S_EXEC && kind_reg != OP_TBL_HIGH
                    && kind_reg != OP_TBL_LOW) || state_reg == S_TBL_WAIT;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= S_IDLE;
         op_reg    <= 24'h000000;
         kind_reg  <= OP_REV_SUB;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (issue && legal) begin
                  op_reg    <= opcode;
                  kind_reg  <= exec_op_t'(op_sel);
                  state_reg <= S_EXEC;
               end
            end
            S_EXEC: begin
               // Table reads wait one cycle for program memory
               if (kind_reg == OP_TBL_HIGH || kind_reg == OP_TBL_LOW)
                  state_reg <= S_TBL_WAIT;
               else
                  state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   chk_table_two_cycle: assert property (@(posedge clk)
      disable iff (!rstn)
      (state_reg == S_EXEC && (kind_reg == OP_TBL_HIGH
       || kind_reg == OP_TBL_LOW)) |=> pmem_re ##1 done)
      else $error("Table read did not finish in two cycles");
   chk_one_cycle_op: assert property (@(posedge clk)
      disable iff (!rstn)
      (state_reg == S_EXEC && kind_reg == OP_REV_SUB) |=> done && !busy)
      else $error("Subtract did not finish in one cycle");

   // ------------------------------------------------------------------
   // Program memory and data memory requests
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pmem_re                  <= 1'b0;
         program_memory_word_addr <= 24'h000000;
      end else begin
         pmem_re <= 1'b0;
         if (state_reg == S_EXEC && (kind_reg == OP_TBL_HIGH
                                     || kind_reg == OP_TBL_LOW)) begin
            pmem_re <= 1'b1;
            // Source always taken indirectly for table reads
            program_memory_word_addr <= {table_page_pointer,
                                         src_ea};
         end
      end
   end

   chk_table_address: assert property (@(posedge clk)
      disable iff (!rstn)
      pmem_re |-> program_memory_word_addr
                  == {$past(table_page_pointer), $past(src_ea)})
      else $error("Table address not page pointer above source");

   // Source address from the opcode at issue, destination on finish,
   // so the address stands beside the write strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dmem_addr <= WORD_RESET;
      end else if (finish) begin
         dmem_addr <= dst_ea;
      end else if (state_reg == S_IDLE && issue && legal) begin
         dmem_addr <= eff_addr(opcode[SRC_MODE_LSB +: 3],
                               regs[opcode[SRC_REG_LSB +: 4]],
                               opcode[SIZE_BIT_POS]);
      end
   end

   // ------------------------------------------------------------------
   // Write-back, pointer updates and status
   // ------------------------------------------------------------------
   logic dest_is_reg;
   assign dest_is_reg = (dmode == MODE_DIRECT) || (kind_reg == OP_SWAP);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 16; i++) regs[i] <= WORD_RESET;
      end else if (finish) begin
         if (kind_reg != OP_SWAP && smode != MODE_DIRECT)
            regs[source_operand_reg] <= upd_reg(smode,
                                  regs[source_operand_reg], bmode);
         if (dest_is_reg)
            regs[wb_reg] <= bus.result;
         else
            regs[dest_operand_reg] <= upd_reg(dmode,
                                  regs[dest_operand_reg], bmode);
      end
   end

   chk_byte_upper_keep: assert property (@(posedge clk)
      disable iff (!rstn)
      (finish && bmode && dest_is_reg) |=>
         wreg_wdata[15:8] == $past(wb_old[15:8]))
      else $error("Byte write changed the upper register byte");
   chk_swap_bytes: assert property (@(posedge clk)
      disable iff (!rstn)
      (finish && kind_reg == OP_SWAP && !bmode) |=>
         wreg_wdata == {$past(wb_old[7:0]), $past(wb_old[15:8])})
      else $error("Word swap did not exchange the bytes");
   chk_swap_nibbles: assert property (@(posedge clk)
      disable iff (!rstn)
      (finish && kind_reg == OP_SWAP && bmode) |=>
         wreg_wdata[7:0] == {$past(wb_old[3:0]), $past(wb_old[7:4])})
      else $error("Byte swap did not exchange the nibbles");
   chk_high_odd_zero: assert property (@(posedge clk)
      disable iff (!rstn)
      (finish && kind_reg == OP_TBL_HIGH && bmode && src_ea[0]
       && dest_is_reg) |=> wreg_wdata[7:0] == 8'h00)
      else $error("Odd byte table high did not give zero");

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy         <= 1'b0;
         done         <= 1'b0;
         status_flags <= 5'h00;
         flags_valid  <= 1'b0;
         wreg_we      <= 1'b0;
         wreg_waddr   <= 4'h0;
         wreg_wdata   <= WORD_RESET;
         dmem_we      <= 1'b0;
         dmem_wdata   <= WORD_RESET;
      end else begin
         busy        <= (state_reg == S_IDLE) ? (issue && legal)
                        : !finish;
         done        <= finish;
         flags_valid <= finish && kind_reg == OP_REV_SUB;
         wreg_we     <= finish && dest_is_reg;
         dmem_we     <= finish && !dest_is_reg;
         if (finish) begin
            wreg_waddr <= wb_reg;
            wreg_wdata <= bus.result;
            dmem_wdata <= bus.result;
            if (kind_reg == OP_REV_SUB)
               status_flags <= bus.flags;
         end
      end
   end
endmodule // exec_unit
`default_nettype wire

// >>> mem_model.sv
// Partner: program memory and data memory behind the execution unit
// Assumes: a program word is read while pmem_re stands and one cycle after
`default_nettype none
module mem_model (
   // Clock
   input  wire logic        clk,
   // Program memory
   input  wire logic        pmem_re,
   input  wire logic [23:0] program_memory_word_addr,
   input  wire logic [23:0] pm_seed,
   output logic      [23:0] program_memory_word,
   // Data memory
   input  wire logic [15:0] dmem_addr,
   output logic      [15:0] dmem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        held;
   logic        tog;
   logic [23:0] addr_reg;
   initial begin
      held = 0;
      tog = 0;
      addr_reg = 0;
   end
   always @(posedge clk) begin
      held <= pmem_re;
      tog <= ~tog;
      if (pmem_re) addr_reg <= program_memory_word_addr;
   end
   // Outside the read window the word changes every cycle
   always_comb begin
      if (pmem_re) program_memory_word = pm_seed ^ program_memory_word_addr;
      else if (held) program_memory_word = pm_seed ^ addr_reg;
      else program_memory_word = {24{tog}} ^ 24'h5AA55A;
   end
   assign dmem_rdata = dmem_addr ^ 16'h3C5A;
endmodule // mem_model
`default_nettype wire

// >>> subtract_swap_table_read_exec_tb.sv
// Testbench: registers loaded by table reads, then all four operations
// Assumes: internal registers reset to zero and register 0 is never written
`default_nettype none
module subtract_swap_table_read_exec_tb
   import exec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rstn, issue, busy, done, flags_valid;
   logic        wreg_we, dmem_we, pmem_re;
   logic [1:0]  op_sel;
   logic [23:0] opcode, program_memory_word_addr, program_memory_word;
   logic [23:0] pm_seed;
   logic [7:0]  table_page_pointer;
   logic [4:0]  status_flags;
   logic [3:0]  wreg_waddr;
   logic [15:0] wreg_wdata, dmem_addr, dmem_wdata, dmem_rdata, v;
   logic [32:0] note_q[$];
   logic [4:0]  flag_q[$];
   logic [15:0] rf[16];
   int          failures, total_checks, seed;
   exec_unit i_exec_unit (.clk, .rstn, .issue, .op_sel, .opcode,
      .table_page_pointer, .busy, .done, .status_flags, .flags_valid,
      .wreg_we, .wreg_waddr, .wreg_wdata, .dmem_we, .dmem_addr,
      .dmem_wdata, .dmem_rdata, .pmem_re, .program_memory_word_addr,
      .program_memory_word);
   mem_model i_mem_model (.clk, .pmem_re, .program_memory_word_addr,
      .pm_seed, .program_memory_word, .dmem_addr, .dmem_rdata);
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic test_done;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [23:0] opc(input logic [3:0] b, input logic bm,
      input logic [2:0] dm, input logic [3:0] d, input logic [2:0] sm,
      input logic [3:0] s);
      return {REV_SUB_PATTERN, b, bm, dm, d, sm, s};
   endfunction
   // Expected {DC,N,OV,Z,C}; DC and C are not-borrow
   function automatic logic [4:0] flg(input logic [15:0] s,
      input logic [15:0] b, input logic bm);
      logic [16:0] d;
      logic [4:0]  n;
      int          m;
      m = bm ? 7 : 15;
      n = {1'b0, s[3:0]} - {1'b0, b[3:0]};
      d = bm ? {9'h0, s[7:0]} - {9'h0, b[7:0]} : {1'b0, s} - {1'b0, b};
      return {~n[4], d[m], (s[m] ^ b[m]) & (d[m] ^ s[m]),
              bm ? d[7:0] == 8'h00 : d[15:0] == 16'h0000, ~d[m+1]};
   endfunction
   task automatic note(input logic [3:0] r, input logic [15:0] val);
      note_q.push_back({13'h0, r, val});
      rf[r] = val;
   endtask
   task automatic run(input exec_op_t op, input logic [23:0] o,
      input logic [7:0] pg, input int lat);
      int n;
      op_sel = op;
      opcode = o;
      table_page_pointer = pg;
      issue = 1;
      @(posedge clk);
      #1 issue = 0;
      check(33'(busy), 33'(lat != 8));
      // The take cycle counts as the first
      n = 1;
      while (done !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1 n++;
      end
      check(33'(n), 33'(lat));
   endtask
   task automatic load(input logic [3:0] r, input logic [15:0] val);
      logic [7:0] pg;
      pg = 8'($random(seed));
      pm_seed = {8'($random(seed)), val} ^ {pg, rf[0]};
      note(r, val);
      run(OP_TBL_LOW, opc(0, 0, MODE_DIRECT, r, MODE_IND, 0), pg, 3);
   endtask
   task automatic sub(input logic [3:0] b, input logic bm, input logic [3:0] d,
      input logic [3:0] s);
      logic [15:0] r;
      r = rf[s] - rf[b];
      flag_q.push_back(flg(rf[s], rf[b], bm));
      note(d, bm ? {rf[d][15:8], r[7:0]} : r);
      run(OP_REV_SUB, opc(b, bm, MODE_DIRECT, d, MODE_DIRECT, s), 0, 2);
   endtask
   task automatic sw(input logic bm, input logic [3:0] r);
      note(r, bm ? {rf[r][15:8], rf[r][3:0], rf[r][7:4]}
                 : {rf[r][7:0], rf[r][15:8]});
      run(OP_SWAP, opc(0, bm, 0, 0, 0, r), 0, 2);
   endtask
   // Word subtract through memory; da and sa are the addresses the modes give
   task automatic msub(input logic [2:0] dm, input logic [2:0] sm,
      input logic [15:0] da, input logic [15:0] sa);
      v = (sa ^ 16'h3C5A) - rf[1];
      flag_q.push_back(flg(sa ^ 16'h3C5A, rf[1], 0));
      note_q.push_back({1'b1, da, v});
      run(OP_REV_SUB, opc(1, 0, dm, 4, sm, 5), 0, 2);
   endtask
   task automatic tbl(input exec_op_t op, input logic bm, input logic [3:0] d,
      input logic [3:0] s);
      logic [7:0]  pg;
      logic [23:0] w;
      logic [7:0]  lo;
      pg = 8'($random(seed));
      pm_seed = 24'($random(seed));
      w = pm_seed ^ {pg, rf[s]};
      if (op == OP_TBL_LOW) lo = rf[s][0] ? w[15:8] : w[7:0];
      else lo = rf[s][0] ? 8'h00 : w[23:16];
      if (bm) note(d, {rf[d][15:8], lo});
      else note(d, op == OP_TBL_LOW ? w[15:0] : {8'h00, w[23:16]});
      run(op, opc(0, bm, MODE_DIRECT, d, MODE_IND, s), pg, 3);
   endtask
   // Every register or memory write is matched to the oldest note
   always @(negedge clk) begin
      if (wreg_we === 1'b1 || dmem_we === 1'b1)
         check(wreg_we ? {13'h0, wreg_waddr, wreg_wdata}
                       : {1'b1, dmem_addr, dmem_wdata},
               note_q.size() ? note_q.pop_front() : 33'h1FFFFFFFF);
      if (flags_valid === 1'b1)
         check({28'h0, status_flags},
               {28'h0, flag_q.size() ? flag_q.pop_front() : 5'h1F});
   end
   initial begin
      #100000;
      failures++;
      test_done;
   end
   initial begin
      seed = 32'h3582;
      failures = 0;
      total_checks = 0;
      {issue, op_sel, opcode, table_page_pointer, pm_seed, rstn} = 0;
      foreach (rf[i]) rf[i] = WORD_RESET;
      repeat (8) @(posedge clk);
      #1 rstn = 1;
      for (int i = 1; i < 7; i++) load(4'(i), 16'($random(seed)));
      load(7, 16'($random(seed)) & 16'hFFFE);
      load(8, 16'($random(seed)) | 16'h0001);
      sub(2, 0, 9, 2);
      for (int i = 0; i < 6; i++)
         sub(4'(1 + ($random(seed) & 7)), i[0], 4'(9 + i[1:0]),
             4'(1 + ($random(seed) & 7)));
      sub(1, 1, 3, 2);
      msub(MODE_IND, MODE_IND, rf[4], rf[5]);
      msub(MODE_PREDEC, MODE_POSTINC, rf[4] - 16'h2, rf[5]);
      rf[4] = rf[4] - 16'h2;
      rf[5] = rf[5] + 16'h2;
      msub(MODE_POSTDEC, MODE_PREINC, rf[4], rf[5] + 16'h2);
      sw(0, 2);
      sw(1, 6);
      for (int bm = 0; bm < 2; bm++) begin
         for (int s = 7; s < 9; s++) begin
            tbl(OP_TBL_LOW, bm[0], 9, 4'(s));
            tbl(OP_TBL_HIGH, bm[0], 10, 4'(s));
         end
      end
      run(OP_REV_SUB, {5'h03, 19'h0}, 0, 8);
      repeat (3) @(posedge clk);
      check(33'(note_q.size() + flag_q.size()), 33'h0);
      test_done;
   end
endmodule // subtract_swap_table_read_exec_tb
`default_nettype wire
